// *** logic/nvac_pkg.sv ***
// Package of constants and types for the nonvolatile access controller
package nvac_pkg;
    // ****************************************
    // Register map (printed offsets are indices, byte address = 4 * index)
    // ****************************************
    localparam logic [9:0] IDX_DATA_LOW = 10'h10C;
    localparam logic [9:0] IDX_ADDR_LOW = 10'h10D;
    localparam logic [9:0] IDX_DATA_HIGH = 10'h10E;
    localparam logic [9:0] IDX_ADDR_HIGH = 10'h10F;
    localparam logic [9:0] IDX_CONTROL = 10'h18C;
    localparam logic [9:0] IDX_UNLOCK = 10'h18D;
    localparam logic [9:0] IDX_FLAGS = 10'h190;
    localparam logic [11:0] ADDR_DATA_LOW = {IDX_DATA_LOW, 2'b00};
    localparam logic [11:0] ADDR_ADDR_LOW = {IDX_ADDR_LOW, 2'b00};
    localparam logic [11:0] ADDR_DATA_HIGH = {IDX_DATA_HIGH, 2'b00};
    localparam logic [11:0] ADDR_ADDR_HIGH = {IDX_ADDR_HIGH, 2'b00};
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'b00};
    localparam logic [11:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};

    // ****************************************
    // Control and flags register fields, high register widths
    // ****************************************
    localparam int BIT_SELECT = 7;
    localparam int BIT_ERROR = 3;
    localparam int BIT_WEN = 2;
    localparam int BIT_WSTART = 1;
    localparam int BIT_RSTART = 0;
    localparam int BIT_DONE = 0;
    localparam int DATA_HIGH_W = 6;
    localparam int ADDR_HIGH_W = 5;

    // ****************************************
    // Unlock keys, reset values, timing
    // ****************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int WRITE_TIME_US = 5;
    localparam int CLK_MHZ = 200;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_KEY1,
        NVAC_KEY2
    } nvac_unlock_t;

    // Request to the memory macros
    typedef struct packed {
        logic rd_data;
        logic wr_data;
        logic rd_prog;
        logic [12:0] addr;
        logic [7:0] wdata;
    } nvac_mem_req_t;
endpackage

// *** logic/nvac_ctrl.sv ***
// Register-driven controller for data and program nonvolatile memory
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Select bit set routes operations to program memory, clear to data.
// - Error flag sets when a data write is cut short by a warm reset; power-on reset clears it.
// - Write enable clear inhibits every data memory write.
// - Write start with data selected begins write; hardware clears it at end.
// - Read start begins a read; software cannot clear it; hardware does.
// - Control bits 6..4 and unused high data and address bits read zero.
// - Low address picks one of 256 data bytes or low program address.
// - High address supplies five upper program address bits.
// - High data holds upper six bits of a program word read.
// - Data read result sits in low data the very next cycle.
// - Low data keeps a read result until next read or software write.
// - Write starts only after 55h, AAh to unlock, then write start.
// - Write start cannot be set unless write enable already set.
// - Clearing write enable during a write does not alter it.
// - Hardware never clears write enable by itself.
// - Write completion clears write start and sets the complete flag.
// - Write start with program selected clears at once, does nothing.
// - Unlock register holds nothing and reads as zero.
// - Low data and address survive a warm reset during a write.
// - Program read uses second cycle after read start is set.
module nvac_ctrl #(
    parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output nvac_pkg::nvac_mem_req_t o_mem_req,
    input wire logic [7:0] i_data_rdata,
    input wire logic [13:0] i_prog_rdata,
    output logic o_cpu_stall,
    output logic o_write_complete_flag
);
    import nvac_pkg::*;

    // ****************************************
    // Bus decode
    // ****************************************
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    assign wbyte = i_pwdata[7:0];
    assign o_pready = 1'b1;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_DATA_LOW) || (a == ADDR_ADDR_LOW) ||
                 (a == ADDR_DATA_HIGH) || (a == ADDR_ADDR_HIGH) ||
                 (a == ADDR_CONTROL) || (a == ADDR_UNLOCK) ||
                 (a == ADDR_FLAGS);
    endfunction
    assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);

    logic wr_dl;
    logic wr_al;
    logic wr_dh;
    logic wr_ah;
    logic wr_ctl;
    logic wr_key;
    logic wr_flg;
    assign wr_dl = wr_acc && (i_paddr == ADDR_DATA_LOW);
    assign wr_al = wr_acc && (i_paddr == ADDR_ADDR_LOW);
    assign wr_dh = wr_acc && (i_paddr == ADDR_DATA_HIGH);
    assign wr_ah = wr_acc && (i_paddr == ADDR_ADDR_HIGH);
    assign wr_ctl = wr_acc && (i_paddr == ADDR_CONTROL);
    assign wr_key = wr_acc && (i_paddr == ADDR_UNLOCK);
    assign wr_flg = wr_acc && (i_paddr == ADDR_FLAGS);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] nv_data_low;
    logic [7:0] nv_address_low;
    logic [DATA_HIGH_W-1:0] nv_data_high;
    logic [ADDR_HIGH_W-1:0] nv_address_high;
    logic memory_select;
    logic write_enable_bit;
    logic write_start;
    logic read_start;
    logic write_error_flag;
    logic write_complete_flag;
    nvac_unlock_t unlock;
    logic [1:0] prog_cnt;
    localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
    logic [TIMER_W-1:0] wtimer;
    logic write_done;
    logic start_write;
    logic data_read;
    logic prog_read;
    logic write_active;

    assign write_done = write_start && (wtimer == 1);
    // Write begins only from unlocked state with enable set and data selected
    assign start_write = wr_ctl && wbyte[BIT_WSTART] && !write_start &&
        (unlock == NVAC_KEY2) && write_enable_bit &&
        !wbyte[BIT_SELECT] && !memory_select;
    assign data_read = read_start && !memory_select && prog_cnt == 2'd0;
    assign prog_read = read_start && memory_select && prog_cnt == 2'd2;

    // ****************************************
    // Unlock detector
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unlock <= NVAC_IDLE;
        end else if (wr_acc) begin
            case (unlock)
                NVAC_IDLE: begin
                    if (wr_key && wbyte == KEY_FIRST) begin
                        unlock <= NVAC_KEY1;
                    end else begin
                        unlock <= NVAC_IDLE;
                    end
                end
                NVAC_KEY1: begin
                    if (wr_key && wbyte == KEY_SECOND) begin
                        unlock <= NVAC_KEY2;
                    end else begin
                        unlock <= NVAC_IDLE;
                    end
                end
                // Any write after the second key closes the window
                NVAC_KEY2: begin
                    unlock <= NVAC_IDLE;
                end
                default: begin
                    unlock <= NVAC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            memory_select <= 1'b0;
        end else if (wr_ctl) begin
            memory_select <= wbyte[BIT_SELECT];
        end
    end

    // Enable changes only by software writes or reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_enable_bit <= 1'b0;
        end else if (wr_ctl) begin
            write_enable_bit <= wbyte[BIT_WEN];
        end
    end

    // ****************************************
    // Write timer
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_start <= 1'b0;
        end else if (start_write) begin
            write_start <= 1'b1;
        end else if (write_done) begin
            write_start <= 1'b0;
        end
    end

    // Timer ignores write enable changes once started
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wtimer <= '0;
        end else if (start_write) begin
            wtimer <= TIMER_W'(WRITE_CYCLES);
        end else if (write_start) begin
            wtimer <= wtimer - 1'b1;
        end
    end

    // Write tracked in the power-on domain so a warm reset still sees it
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            write_active <= 1'b0;
        end else if (!i_rst_n) begin
            write_active <= 1'b0;
        end else if (start_write) begin
            write_active <= 1'b1;
        end else if (write_done) begin
            write_active <= 1'b0;
        end
    end

    // ****************************************
    // Read sequencer
    // ****************************************
    // Read start is set by software and cleared only here
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_start <= 1'b0;
        end else if (data_read || prog_read) begin
            read_start <= 1'b0;
        end else if (wr_ctl && wbyte[BIT_RSTART]) begin
            read_start <= 1'b1;
        end
    end

    // Counts the ignored instruction slot of a program read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_cnt <= 2'd0;
        end else if (data_read || prog_read) begin
            prog_cnt <= 2'd0;
        end else if (read_start) begin
            prog_cnt <= prog_cnt + 2'd1;
        end else if (wr_ctl && wbyte[BIT_RSTART]) begin
            prog_cnt <= wbyte[BIT_SELECT] ? 2'd1 : 2'd0;
        end
    end

    // ****************************************
    // Write error flag
    // ****************************************
    // Error flag survives warm resets; a reset mid write sets it
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            write_error_flag <= 1'b0;
        end else if (!i_rst_n) begin
            if (write_active) begin
                write_error_flag <= 1'b1;
            end
        end else if (write_done) begin
            write_error_flag <= 1'b0;
        end else if (wr_ctl) begin
            write_error_flag <= wbyte[BIT_ERROR];
        end
    end

    // ****************************************
    // Write complete flag
    // ****************************************
    // Set wins over software clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_complete_flag <= 1'b0;
        end else if (write_done) begin
            write_complete_flag <= 1'b1;
        end else if (wr_flg && !wbyte[BIT_DONE]) begin
            write_complete_flag <= 1'b0;
        end
    end
    assign o_write_complete_flag = write_complete_flag;

    // ****************************************
    // Address registers (kept across warm reset)
    // ****************************************
    // Low address is frozen while a write is busy
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            nv_address_low <= RESET_BYTE;
        end else if (wr_al && !write_start) begin
            nv_address_low <= wbyte;
        end
    end

    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            nv_address_high <= '0;
        end else if (wr_ah) begin
            nv_address_high <= wbyte[ADDR_HIGH_W-1:0];
        end
    end

    // ****************************************
    // Data registers (kept across warm reset)
    // ****************************************
    // Low data takes read results or a software byte for writing
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            nv_data_low <= RESET_BYTE;
        end else if (data_read) begin
            nv_data_low <= i_data_rdata;
        end else if (prog_read) begin
            nv_data_low <= i_prog_rdata[7:0];
        end else if (wr_dl && !write_start) begin
            nv_data_low <= wbyte;
        end
    end

    // High data holds the upper bits of a program word
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            nv_data_high <= '0;
        end else if (prog_read) begin
            nv_data_high <= i_prog_rdata[13:8];
        end else if (wr_dh) begin
            nv_data_high <= wbyte[DATA_HIGH_W-1:0];
        end
    end

    // ****************************************
    // Memory requests
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_req <= '0;
        end else begin
            // Data read strobe in the cycle after read start
            o_mem_req.rd_data <= wr_ctl && wbyte[BIT_RSTART] &&
                !wbyte[BIT_SELECT] && !read_start;
            // Program read strobe in the second cycle
            o_mem_req.rd_prog <= read_start && memory_select &&
                prog_cnt == 2'd1;
            // Write strobe only with enable set
            o_mem_req.wr_data <= start_write && write_enable_bit;
            o_mem_req.addr <= {nv_address_high, nv_address_low};
            o_mem_req.wdata <= nv_data_low;
        end
    end
    // Instruction slot consumed by a program read is stalled
    assign o_cpu_stall = read_start && memory_select && prog_cnt == 2'd1;

    // ****************************************
    // Read mux
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= '0;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                ADDR_DATA_LOW: begin
                    o_prdata <= {24'h000000, nv_data_low};
                end
                ADDR_ADDR_LOW: begin
                    o_prdata <= {24'h000000, nv_address_low};
                end
                ADDR_DATA_HIGH: begin
                    o_prdata <= {26'h0000000, nv_data_high};
                end
                ADDR_ADDR_HIGH: begin
                    o_prdata <= {27'h0000000, nv_address_high};
                end
                ADDR_CONTROL: begin
                    o_prdata <= {24'h000000, memory_select, 3'h0,
                        write_error_flag, write_enable_bit,
                        write_start, read_start};
                end
                ADDR_FLAGS: begin
                    o_prdata <= {31'h00000000, write_complete_flag};
                end
                ADDR_UNLOCK: begin
                    o_prdata <= '0;
                end
                default: begin
                    o_prdata <= '0;
                end
            endcase
        end
    end
endmodule // nvac_ctrl

`default_nettype wire

// *** verif/nvac_chk.sv ***
// Checker of the nonvolatile access controller port behaviour
`timescale 1ns/10ps
`default_nettype none
module nvac_chk
import nvac_pkg::*;
#(
    parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire nvac_pkg::nvac_mem_req_t o_mem_req,
    input wire logic [7:0] i_data_rdata,
    input wire logic [13:0] i_prog_rdata,
    input wire logic o_cpu_stall,
    input wire logic o_write_complete_flag
);
    logic wr_acc;
    logic rd_acc;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_por_n);
    // ****************************************
    // Assertions
    // ****************************************
    a_data_read_next: assert property (wr_acc && i_paddr == ADDR_CONTROL
        && i_pwdata == 32'h01 |=> o_mem_req.rd_data && !o_mem_req.rd_prog)
        else $error("data read not issued next cycle");
    a_prog_read_slot: assert property (wr_acc && i_paddr == ADDR_CONTROL
        && i_pwdata == 32'h81 |=> o_cpu_stall ##1 o_mem_req.rd_prog)
        else $error("program read not in second cycle");
    a_prog_no_write: assert property (wr_acc && i_paddr == ADDR_CONTROL
        && i_pwdata[7] && i_pwdata[1] |=> !o_mem_req.wr_data [*3])
        else $error("write started with program selected");
    a_unlock_reads_zero: assert property (rd_acc
        && i_paddr == ADDR_UNLOCK |-> o_prdata == 32'h0)
        else $error("unlock register read not zero");
    a_ctrl_unused_zero: assert property (rd_acc && i_paddr == ADDR_CONTROL
        |-> o_prdata[31:8] == 24'h0 && o_prdata[6:4] == 3'h0)
        else $error("control unused bits not zero");
    a_data_high_zero: assert property (rd_acc
        && i_paddr == ADDR_DATA_HIGH |-> o_prdata[31:6] == 26'h0)
        else $error("data high unused bits not zero");
    a_addr_high_zero: assert property (rd_acc
        && i_paddr == ADDR_ADDR_HIGH |-> o_prdata[31:5] == 27'h0)
        else $error("address high unused bits not zero");
    a_write_one_pulse: assert property ($rose(o_mem_req.wr_data)
        |=> !o_mem_req.wr_data)
        else $error("write request longer than one cycle");
    a_flag_holds: assert property (o_write_complete_flag
        && !(wr_acc && i_paddr == ADDR_FLAGS) |=> o_write_complete_flag)
        else $error("complete flag cleared without software");
    c_prog_read: cover property (o_mem_req.rd_prog);
    c_data_write: cover property (o_mem_req.wr_data);
    c_bad_addr: cover property (i_psel && i_penable && o_pslverr);
endmodule // nvac_chk
bind nvac_ctrl nvac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvac_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_mem_req(o_mem_req),
    .i_data_rdata(i_data_rdata), .i_prog_rdata(i_prog_rdata),
    .o_cpu_stall(o_cpu_stall), .o_write_complete_flag(o_write_complete_flag));
`default_nettype wire

// *** verif/tb_top.sv ***
// Testbench of the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import nvac_pkg::*;
    localparam int WC = 10;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_por_n = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, q;
    logic o_pready, o_pslverr, o_cpu_stall, o_write_complete_flag, serr;
    nvac_mem_req_t o_mem_req;
    logic [7:0] i_data_rdata, wr_addr, wr_dat, dmem;
    logic [13:0] i_prog_rdata;
    logic [11:0] ra [7];
    int errors = 0, compares = 0, wr_seen = 0;
    always #2.5 i_clk = ~i_clk;
    // ****************************************
    // Memory stand-ins
    // ****************************************
    assign dmem = o_mem_req.addr[7:0] ^ 8'h5A;
    assign i_data_rdata = o_mem_req.rd_data ? dmem : ~dmem;
    assign i_prog_rdata = {o_mem_req.addr, o_mem_req.rd_prog};
    always @(posedge i_clk) if (o_mem_req.wr_data) begin
        wr_seen <= wr_seen + 1;
        wr_addr <= o_mem_req.addr[7:0];
        wr_dat <= o_mem_req.wdata;
    end
    nvac_ctrl #(.WRITE_CYCLES(WC)) i_nvac_ctrl (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_mem_req(o_mem_req),
        .i_data_rdata(i_data_rdata), .i_prog_rdata(i_prog_rdata),
        .o_cpu_stall(o_cpu_stall),
        .o_write_complete_flag(o_write_complete_flag));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        i_psel <= 1'b1; i_penable <= 1'b0;
        i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin @(posedge i_clk); n++; end
        while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin errors++; results(); end
        q = o_prdata; serr = o_pslverr;
        i_psel <= 1'b0; i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic start_write(input logic [31:0] c);
        wr(ADDR_UNLOCK, 32'h55);
        wr(ADDR_UNLOCK, 32'hAA);
        wr(ADDR_CONTROL, c);
    endtask
    task automatic wait_flag();
        int n;
        for (n = 0; n < 200 && o_write_complete_flag !== 1'b1; n++)
            @(posedge i_clk);
        if (n >= 200) begin errors++; results(); end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        ra = '{ADDR_DATA_LOW, ADDR_ADDR_LOW, ADDR_DATA_HIGH, ADDR_ADDR_HIGH,
               ADDR_CONTROL, ADDR_UNLOCK, ADDR_FLAGS};
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1; i_por_n <= 1'b1;
        @(posedge i_clk);
        foreach (ra[k]) rd(ra[k], 32'h0);
        for (int k = 1; k < 4; k++) begin
            wr(ra[k], 32'hFFFF_FFFF);
            rd(ra[k], k == 1 ? 32'hFF : (k == 2 ? 32'h3F : 32'h1F));
        end
        wr(12'h700, 32'h1); chk(serr, 1'b1);
        rd(12'h700, 32'h0); chk(serr, 1'b1);
        wr(ADDR_ADDR_LOW, 32'h3C); wr(ADDR_CONTROL, 32'h01);
        rd(ADDR_DATA_LOW, 32'h3C ^ 32'h5A);
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_DATA_LOW, 32'h3C ^ 32'h5A);
        wr(ADDR_ADDR_HIGH, 32'h15); wr(ADDR_ADDR_LOW, 32'hA7);
        wr(ADDR_CONTROL, 32'h81); repeat (2) @(posedge i_clk);
        rd(ADDR_DATA_LOW, 32'h4F);
        rd(ADDR_DATA_HIGH, 32'h2B);
        rd(ADDR_CONTROL, 32'h80);
        start_write(32'h86); rd(ADDR_CONTROL, 32'h84);
        wr(ADDR_CONTROL, 32'h0); start_write(32'h02);
        rd(ADDR_CONTROL, 32'h0);
        wr(ADDR_CONTROL, 32'h04);
        wr(ADDR_UNLOCK, 32'h55); wr(ADDR_ADDR_LOW, 32'h21);
        wr(ADDR_UNLOCK, 32'hAA); wr(ADDR_CONTROL, 32'h06);
        rd(ADDR_CONTROL, 32'h04);
        chk(wr_seen, 0);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_ADDR_LOW, 32'h21 + k); wr(ADDR_DATA_LOW, 32'h9C + k);
            wr(ADDR_CONTROL, 32'h04); start_write(32'h06);
            rd(ADDR_CONTROL, 32'h06);
            if (k == 0) wr(ADDR_CONTROL, 32'h0);
            wr(ADDR_ADDR_LOW, 32'h77);
            wait_flag();
            chk(wr_seen, k + 1);
            chk(wr_addr, 8'h21 + k);
            chk(wr_dat, 8'h9C + k);
            rd(ADDR_CONTROL, k ? 32'h04 : 32'h0);
            rd(ADDR_FLAGS, 32'h1);
            repeat (4) @(posedge i_clk);
            chk(o_write_complete_flag, 1'b1);
            wr(ADDR_FLAGS, 32'h0); rd(ADDR_FLAGS, 32'h0);
        end
        wr(ADDR_ADDR_LOW, 32'h44); wr(ADDR_DATA_LOW, 32'h66);
        wr(ADDR_CONTROL, 32'h04); start_write(32'h06);
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b0; repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1; @(posedge i_clk);
        rd(ADDR_CONTROL, 32'h08);
        rd(ADDR_ADDR_LOW, 32'h44);
        rd(ADDR_DATA_LOW, 32'h66);
        results();
    end
endmodule // tb_top
`default_nettype wire
